/* design/dcpc_pkg.sv */
/*
 * Shared constants and types for the dual channel pulse counter.
 * Assumes a single 50 MHz module clock; no register bus.
 */
package dcpc_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;      // Module clock period
    localparam int MS_TICK_NS = 1000000;    // One millisecond
    localparam int MS_TICK_CYC = MS_TICK_NS / CLK_PERIOD_NS;
    localparam int ON_TIME_W = 14;          // On-time, 0..16383 ms
    localparam int RATE_W = 16;             // Rate sample width
    localparam int CNT_W = 32;              // Counter storage width

    // ------------------------------------------------------------
    // Counter arrangement
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DCPC_TWO16 = 2'h0,
        DCPC_ONE32 = 2'h1,
        DCPC_TWO32 = 2'h2
    } dcpc_arr_t;

    // ------------------------------------------------------------
    // Output coil modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DCPC_OFF = 3'h0,
        DCPC_SETP = 3'h1,
        DCPC_LSETP = 3'h2,
        DCPC_TERM = 3'h3,
        DCPC_LTERM = 3'h4,
        DCPC_TSETP = 3'h5,
        DCPC_TTERM = 3'h6
    } dcpc_omode_t;

    // ------------------------------------------------------------
    // Field pin layout per channel in the sync vector
    // ------------------------------------------------------------
    localparam int PIN_A = 0;       // Count input A
    localparam int PIN_B = 1;       // Quadrature input B
    localparam int PIN_DIR = 2;     // Direction, high = up
    localparam int PIN_EN = 3;      // Hardware enable
    localparam int PIN_PRE = 4;     // Hardware preset
    localparam int PIN_ORST = 5;    // Hardware output reset
    localparam int PINS_PER_CH = 6;

    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] MAX_RST = 32'h0000_ffff;
endpackage

/* design/dcpc_counter.sv */
/*
 * Dual channel pulse / quadrature counter with setpoint and
 * terminal count outputs, a timed output on the first timed-mode coil and rate sampling.
 * Assumes field pins are asynchronous; configuration ports are
 * synchronous to ref_clk and load strobes are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module dcpc_counter
    import dcpc_pkg::*;
#(
    parameter int TICK_CYC = MS_TICK_CYC  // Cycles per millisecond
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] pin_a,
    input wire logic [1:0] pin_b,
    input wire logic [1:0] pin_dir_up,
    input wire logic [1:0] pin_hw_en,
    input wire logic [1:0] pin_preset,
    input wire logic [1:0] pin_out_rst,
    input wire logic cfg_quad,
    input wire logic cfg_rate,
    input wire logic [1:0] cfg_arr,
    input wire logic cfg_comm_keep,
    input wire logic comm_ok,
    input wire logic plc_run,
    input wire logic [11:0] cfg_omode,
    input wire logic [1:0] sw_en_clr,
    input wire logic [1:0] sw_preset,
    input wire logic [1:0] load_max,
    input wire logic [1:0] load_sp,
    input wire logic [1:0] load_rate,
    input wire logic load_on_time,
    input wire logic [63:0] max_in,
    input wire logic [63:0] sp_in,
    input wire logic [31:0] rate_time_in,
    input wire logic [ON_TIME_W-1:0] on_time_in,
    output logic [63:0] count_out,
    output logic [31:0] rate_out,
    output logic [1:0] sw_en_out,
    output logic [3:0] out_sw
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Width mask of a counter under an arrangement
    function automatic logic [CNT_W-1:0] wmask(input logic [1:0] arr, input logic rate);
        if (rate || arr == DCPC_TWO16) begin
            wmask = 32'h0000_ffff;
        end else begin
            wmask = 32'hffff_ffff;
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int NPIN = 2 * PINS_PER_CH;
    logic [NPIN-1:0] pins;              // Raw field pins
    logic [NPIN-1:0] s1_r, s2_r, pv_r;  // Sync stages and history
    logic [15:0] tick_r, tick_nxt;      // Millisecond divider
    logic tick;                         // Millisecond strobe
    logic [CNT_W-1:0] cnt_r [2], cnt_nxt [2];
    logic [CNT_W-1:0] max_r [2], max_nxt [2];
    logic [CNT_W-1:0] sp_r [2], sp_nxt [2];
    logic [RATE_W-1:0] rtime_r [2], rtime_nxt [2];
    logic [RATE_W-1:0] rtmr_r [2], rtmr_nxt [2];
    logic [RATE_W-1:0] acc_r [2], acc_nxt [2];
    logic [RATE_W-1:0] rate_r [2], rate_nxt [2];
    logic [1:0] swen_r, swen_nxt;       // Software enables
    logic [1:0] tch_r, tch_nxt;         // Terminal hold until next count
    logic [1:0] ev, wrap, sp_hit, pre, orst;
    logic [3:0] lat_r, lat_nxt;         // Latched outputs
    logic [3:0] out_r, out_nxt;
    logic [ON_TIME_W-1:0] ont_r, ont_nxt;   // Programmed on-time
    logic [ON_TIME_W-1:0] tmr_r, tmr_nxt;   // Timed output countdown
    logic [2:0] tidx;                   // First timed output, 4 = none
    logic [CNT_W-1:0] msk, mx;
    logic [2:0] om;
    logic ena, up, trig, allow;
    int ch;

    assign tick = (tick_r == 16'(TICK_CYC - 1));

    // Pin vector assembly
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            pins[c*PINS_PER_CH+PIN_A] = pin_a[c];
            pins[c*PINS_PER_CH+PIN_B] = pin_b[c];
            pins[c*PINS_PER_CH+PIN_DIR] = pin_dir_up[c];
            pins[c*PINS_PER_CH+PIN_EN] = pin_hw_en[c];
            pins[c*PINS_PER_CH+PIN_PRE] = pin_preset[c];
            pins[c*PINS_PER_CH+PIN_ORST] = pin_out_rst[c];
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        msk = wmask(cfg_arr, cfg_rate);
        tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
        swen_nxt = swen_r;
        tch_nxt = tch_r;
        ont_nxt = load_on_time ? on_time_in : ont_r;
        for (int c = 0; c < 2; c++) begin
            cnt_nxt[c] = cnt_r[c];
            max_nxt[c] = load_max[c] ? (max_in[c*32 +: 32] & msk) : max_r[c];
            sp_nxt[c] = load_sp[c] ? (sp_in[c*32 +: 32] & msk) : sp_r[c];
            rtime_nxt[c] = load_rate[c] ? rate_time_in[c*16 +: 16] : rtime_r[c];
            rtmr_nxt[c] = rtmr_r[c];
            acc_nxt[c] = acc_r[c];
            rate_nxt[c] = rate_r[c];
            mx = max_nxt[c];
            up = s2_r[c*PINS_PER_CH+PIN_DIR];
            // Count edge: A rise, or any A/B edge in quadrature
            if (cfg_quad) begin
                ev[c] = (s2_r[c*PINS_PER_CH+PIN_A] ^ pv_r[c*PINS_PER_CH+PIN_A])
                      | (s2_r[c*PINS_PER_CH+PIN_B] ^ pv_r[c*PINS_PER_CH+PIN_B]);
            end else begin
                ev[c] = s2_r[c*PINS_PER_CH+PIN_A] & ~pv_r[c*PINS_PER_CH+PIN_A];
            end
            // Channel 1 idle when both channels form one counter
            ena = s2_r[c*PINS_PER_CH+PIN_EN] & swen_r[c]
                & ~(c == 1 && cfg_arr == DCPC_ONE32);
            ev[c] = ev[c] & ena;
            // Pin edge, software preset, max load or rate load all preset; preset wins over enable clear
            pre[c] = (s2_r[c*PINS_PER_CH+PIN_PRE] & ~pv_r[c*PINS_PER_CH+PIN_PRE])
                   | sw_preset[c] | load_max[c] | load_rate[c];
            orst[c] = s2_r[c*PINS_PER_CH+PIN_ORST];
            wrap[c] = 1'b0;
            if (pre[c]) begin
                cnt_nxt[c] = up ? CNT_RST : mx;
                swen_nxt[c] = 1'b1;
                acc_nxt[c] = '0;
                rtmr_nxt[c] = '0;
                tch_nxt[c] = 1'b0;
            end else begin
                if (sw_en_clr[c]) begin
                    swen_nxt[c] = 1'b0;
                end
                if (ev[c]) begin
                    tch_nxt[c] = 1'b0;
                    if (up) begin
                        wrap[c] = (cnt_r[c] >= mx);
                        cnt_nxt[c] = wrap[c] ? CNT_RST : ((cnt_r[c] + 32'h1) & msk);
                    end else begin
                        wrap[c] = (cnt_r[c] == CNT_RST);
                        cnt_nxt[c] = wrap[c] ? mx : cnt_r[c] - 32'h1;
                    end
                    tch_nxt[c] = wrap[c];
                end
                // Rate sampling: events per programmed interval
                if (cfg_rate) begin
                    acc_nxt[c] = acc_r[c] + RATE_W'(ev[c]);
                    if (tick) begin
                        if (rtmr_r[c] + 16'h1 >= rtime_r[c]) begin
                            rate_nxt[c] = acc_nxt[c];
                            acc_nxt[c] = '0;
                            rtmr_nxt[c] = '0;
                        end else begin
                            rtmr_nxt[c] = rtmr_r[c] + 16'h1;
                        end
                    end
                end
            end
            sp_hit[c] = ev[c] & (cnt_nxt[c] == sp_r[c]);
        end

        // First output holding a timed mode owns the on-time
        tidx = 3'h4;
        for (int k = 3; k >= 0; k--) begin
            if (cfg_omode[k*3 +: 3] == DCPC_TSETP || cfg_omode[k*3 +: 3] == DCPC_TTERM) begin
                tidx = 3'(k);
            end
        end
        tmr_nxt = (tick && tmr_r != '0) ? tmr_r - 14'h1 : tmr_r;

        // Output evaluation per coil
        allow = ~cfg_rate & (cfg_arr == DCPC_TWO16 || cfg_arr == DCPC_ONE32)
              & (comm_ok | cfg_comm_keep);
        for (int k = 0; k < 4; k++) begin
            ch = k / 2;
            om = cfg_omode[k*3 +: 3];
            if (om == DCPC_LSETP || om == DCPC_TSETP) begin
                trig = sp_hit[ch];
            end else begin
                trig = wrap[ch];
            end
            // Set wins over clear; clear by field reset or stop
            lat_nxt[k] = trig | (lat_r[k] & ~orst[ch] & plc_run);
            if (k == 32'(tidx) && trig) begin
                tmr_nxt = ont_r;
            end
            case (om)
                DCPC_SETP: out_nxt[k] = (cnt_r[ch] == sp_r[ch]);
                DCPC_LSETP, DCPC_LTERM: out_nxt[k] = lat_r[k];
                DCPC_TERM: out_nxt[k] = tch_r[ch];
                DCPC_TSETP, DCPC_TTERM: out_nxt[k] = (k == 32'(tidx)) && (tmr_r != '0);
                default: out_nxt[k] = 1'b0;
            endcase
            if (!allow || (ch == 1 && cfg_arr == DCPC_ONE32)) begin
                out_nxt[k] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            pv_r <= '0;
            tick_r <= '0;
            swen_r <= '0;
            tch_r <= '0;
            lat_r <= '0;
            out_r <= '0;
            ont_r <= '0;
            tmr_r <= '0;
            for (int c = 0; c < 2; c++) begin
                cnt_r[c] <= CNT_RST;
                max_r[c] <= MAX_RST;
                sp_r[c] <= CNT_RST;
                rtime_r[c] <= '0;
                rtmr_r[c] <= '0;
                acc_r[c] <= '0;
                rate_r[c] <= '0;
            end
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            pv_r <= s2_r;
            tick_r <= tick_nxt;
            swen_r <= swen_nxt;
            tch_r <= tch_nxt;
            lat_r <= lat_nxt;
            out_r <= out_nxt;
            ont_r <= ont_nxt;
            tmr_r <= tmr_nxt;
            cnt_r <= cnt_nxt;
            max_r <= max_nxt;
            sp_r <= sp_nxt;
            rtime_r <= rtime_nxt;
            rtmr_r <= rtmr_nxt;
            acc_r <= acc_nxt;
            rate_r <= rate_nxt;
        end
    end

    // Outputs straight from flops
    assign count_out = {cnt_r[1], cnt_r[0]};
    assign rate_out = {rate_r[1], rate_r[0]};
    assign sw_en_out = swen_r;
    assign out_sw = out_r;
endmodule
`default_nettype wire

/* bench/dcpc_counter_props.sv */
/* Port checker for the pulse counter, mostly channel 0.
   Assumes direction and preset pins are held for several cycles. */
`timescale 1ns/1ps
`default_nettype none
module dcpc_counter_props
    import dcpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] pin_dir_up,
    input wire logic [1:0] pin_preset,
    input wire logic cfg_rate,
    input wire logic [1:0] cfg_arr,
    input wire logic cfg_comm_keep,
    input wire logic comm_ok,
    input wire logic [11:0] cfg_omode,
    input wire logic [1:0] sw_preset,
    input wire logic [1:0] load_max,
    input wire logic [1:0] load_sp,
    input wire logic [1:0] load_rate,
    input wire logic [63:0] max_in,
    input wire logic [63:0] count_out,
    input wire logic [1:0] sw_en_out,
    input wire logic [3:0] out_sw
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Count and output checks
    // ------------------------------------------------------------
    a_up_preset_zero: assert property ((sw_preset[0] | load_max[0]) && pin_dir_up[0] && $past(pin_dir_up[0], 3)
        |=> count_out[31:0] == 32'h0) else $error("up preset not zero");
    a_dn_load_max: assert property (load_max[0] && !pin_dir_up[0] && !$past(pin_dir_up[0], 3)
        && max_in[31:16] == 16'h0 |=> count_out[31:0] == $past(max_in[31:0])) else $error("down load not max");
    a_preset_sets_en: assert property ((sw_preset[0] | load_max[0]) |=> sw_en_out[0])
        else $error("enable not set");
    a_off_hold_count: assert property (!sw_en_out[0] && !(sw_preset[0] | load_max[0] | load_rate[0])
        && !pin_preset[0] && !$past(pin_preset[0], 2) && !$past(pin_preset[0], 4)
        |=> $stable(count_out[31:0])) else $error("disabled count moved");
    a_term_on_wrap: assert property (cfg_omode[5:3] == DCPC_TERM && $stable(cfg_omode) && $rose(out_sw[1])
        && pin_dir_up[0] && $past(pin_dir_up[0], 4) |-> $past(count_out[31:0]) == 32'h0) else $error("term off wrap");
    a_setp_off_move: assert property (cfg_omode[2:0] == DCPC_SETP && $stable(cfg_omode) && out_sw[0]
        && $changed(count_out[31:0]) && !load_sp[0] && !$past(load_sp[0]) |=> !out_sw[0]) else $error("setpoint stuck");
    a_no_out_mode: assert property ((cfg_rate || cfg_arr == DCPC_TWO32) [*2] |-> out_sw == 4'h0)
        else $error("output in no-output mode");
    a_comm_loss_off: assert property ((!comm_ok && !cfg_comm_keep) [*2] |-> out_sw == 4'h0)
        else $error("output on comm loss");
    a_one32_ch1_off: assert property (cfg_arr == DCPC_ONE32 [*2] |-> out_sw[3:2] == 2'h0)
        else $error("channel 1 output in one32");
endmodule
`default_nettype wire

/* bench/dcpc_enc_src.sv */
/* Encoder pulse source for the field side of the counter.
   Assumes step requests are one-cycle pulses several cycles apart. */
`timescale 1ns/1ps
`default_nettype none
module dcpc_enc_src (
    input wire logic ref_clk,
    input wire logic step,
    input wire logic quad,
    output logic a,
    output logic b
);
    logic [1:0] ph_r = 2'h0; // Shaft phase
    // ------------------------------------------------------------
    // One edge per step; pulse mode toggles A only
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (step) begin
            ph_r <= ph_r + (quad ? 2'h1 : 2'h2);
        end
    end
    assign a = ph_r[1];
    assign b = quad & (ph_r[1] ^ ph_r[0]); // B idle low in pulse mode
endmodule
`default_nettype wire

/* bench/tb.sv */
/* Self-checking bench for the pulse counter with an encoder source.
   Assumes the checker is bound below; one 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcpc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, step = 1'b0, a, b;
    logic dir = 1'b1, hen = 1'b1, hpre = 1'b0, orst = 1'b0, quad = 1'b1, rate = 1'b0, keep = 1'b1, comm = 1'b1, run = 1'b1;
    logic [1:0] arr = 2'h0, swen;
    logic [11:0] omode = 12'h0;
    logic [10:0] stb = 11'h0; // Strobes: preset, max, sp, rate, en clear, on-time
    logic [63:0] maxv = 64'h0, spv = 64'h0, cnt;
    logic [31:0] rtime = 32'h2, rte, ex, mx, sp;
    logic [13:0] ont = 14'h3;
    logic [3:0] osw;
    int err_count = 0, comparisons = 0, k;
    always #10 ref_clk = ~ref_clk;
    dcpc_enc_src u_src (.ref_clk(ref_clk), .step(step), .quad(quad), .a(a), .b(b));
    dcpc_counter #(.TICK_CYC(10)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .pin_a({a, a}), .pin_b({b, b}),
        .pin_dir_up({dir, dir}), .pin_hw_en({hen, hen}), .pin_preset({hpre, hpre}), .pin_out_rst({orst, orst}),
        .cfg_quad(quad), .cfg_rate(rate), .cfg_arr(arr), .cfg_comm_keep(keep), .comm_ok(comm), .plc_run(run),
        .cfg_omode(omode), .sw_preset(stb[1:0]), .load_max(stb[3:2]), .load_sp(stb[5:4]), .load_rate(stb[7:6]),
        .sw_en_clr(stb[9:8]), .load_on_time(stb[10]), .max_in(maxv), .sp_in(spv), .rate_time_in(rtime),
        .on_time_in(ont), .count_out(cnt), .rate_out(rte), .sw_en_out(swen), .out_sw(osw));
    // Next count after one event, with wrap at both ends
    function automatic logic [31:0] nxt(input logic [31:0] c, input logic up, input logic [31:0] m);
        if (up) return (c == m) ? 32'h0 : c + 32'h1;
        return (c == 32'h0) ? m : c - 32'h1;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic st(input int i);
        stb[i] = 1'b1;
        cy(1);
        stb[i] = 1'b0;
        cy(4);
    endtask
    // Encoder steps with random spacing; live says whether the expected count ex follows them
    task automatic steps(input int n, input bit live);
        repeat (n) begin
            step = 1'b1;
            cy(1);
            step = 1'b0;
            if (live && (quad || a)) ex = nxt(ex, dir, mx);
            cy(5 + $urandom % 4);
        end
        cy(3);
    endtask
    initial begin
        void'($urandom(32'h749ee434));
        cy(20);
        rst_n = 1'b1;
        cy(4); // Let the pin synchronisers settle before the first preset
        mx = 32'h3 + $urandom % 6;
        sp = mx >> 1;
        maxv = {mx, mx};
        spv = {32'h0, sp};
        omode = {6'h0, DCPC_TERM, DCPC_SETP};
        st(2);
        ex = 32'h0;
        chk("count_load", ex, cnt[31:0]);
        chk("sw_en", 1, swen[0]);
        st(4);
        steps(sp, 1);
        chk("setp_on", 1, osw[0]);
        steps(mx - sp, 1);
        chk("count_max", ex, cnt[31:0]);
        chk("setp_off", 0, osw[0]);
        steps(1, 1);
        chk("wrap", ex, cnt[31:0]);
        chk("term_on", 1, osw[1]);
        $display("test up done");
        dir = 1'b0;
        cy(4);
        st(2);
        ex = mx;
        chk("count_dn", ex, cnt[31:0]);
        steps(mx + 1, 1);
        chk("dn_wrap", ex, cnt[31:0]);
        $display("test down done");
        hen = 1'b0;
        steps(3, 0);
        chk("hw_off", ex, cnt[31:0]);
        hen = 1'b1;
        st(8);
        chk("sw_en_clr", 0, swen[0]);
        steps(2, 0);
        chk("sw_off", ex, cnt[31:0]);
        hpre = 1'b1;
        cy(10);
        hpre = 1'b0;
        cy(6);
        ex = mx;
        chk("hw_preset", ex, cnt[31:0]);
        chk("hw_en_set", 1, swen[0]);
        chk("ch1_en_set", 1, swen[1]);
        chk("ch1_preset", MAX_RST, cnt[63:32]);
        quad = 1'b0;
        steps(4, 1);
        chk("pulse", ex, cnt[31:0]);
        quad = 1'b1;
        $display("test enable done");
        dir = 1'b1;
        omode = {6'h0, DCPC_TERM, DCPC_LSETP};
        for (k = 0; k < 2; k++) begin
            cy(4);
            st(0);
            ex = 32'h0;
            steps(sp + 1, 1);
            chk("latch_hold", 1, osw[0]);
            if (k == 0) orst = 1'b1;
            else run = 1'b0;
            cy(3);
            {orst, run} = 2'b01;
            cy(2);
            chk("latch_clr", 0, osw[0]);
        end
        $display("test latch done");
        omode = {6'h0, DCPC_TTERM, DCPC_TSETP};
        st(10);
        st(0);
        ex = 32'h0;
        steps(sp, 1);
        chk("timed_on", 1, osw[0]);
        for (k = 0; k < 60 && osw[0] === 1'b1; k++) cy(1);
        if (osw[0] !== 1'b0) begin
            err_count++;
            wrap_up();
        end
        chk("timed_len", 1, k >= 10);
        steps(mx - sp + 1, 1);
        chk("second_timed", 0, osw[1]);
        $display("test timed done");
        omode = {4{DCPC_SETP}};
        for (k = 0; k < 4; k++) begin
            arr = (k == 0) ? 2'h2 : (k == 2) ? 2'h1 : 2'h0;
            comm = ~k[0];
            keep = (k != 1);
            st(0);
            steps(sp, 1);
            chk("out_gate", k[1], osw[0]);
        end
        {arr, comm, keep} = 4'h3;
        $display("test gating done");
        rate = 1'b1;
        st(6);
        steps(8, 0);
        chk("rate_live", 1, rte[15:0] != 16'h0);
        cy(80);
        chk("rate_idle", 0, rte[15:0]);
        $display("test rate done");
        wrap_up();
    end
endmodule
bind dcpc_counter dcpc_counter_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .pin_dir_up(pin_dir_up),
    .pin_preset(pin_preset), .cfg_rate(cfg_rate), .cfg_arr(cfg_arr), .cfg_comm_keep(cfg_comm_keep),
    .comm_ok(comm_ok), .cfg_omode(cfg_omode), .sw_preset(sw_preset), .load_max(load_max), .load_sp(load_sp),
    .load_rate(load_rate), .max_in(max_in), .count_out(count_out), .sw_en_out(sw_en_out), .out_sw(out_sw));
`default_nettype wire
